/* common/cmp_timer_params.svh */
`ifndef CMP_TIMER_PARAMS_SVH
`define CMP_TIMER_PARAMS_SVH

// Timing
`define CLK_PERIOD_NS        5
`define TICK_PERIOD_MS       1
`define MS_TICK_CYCLES_DEF   (`TICK_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define MS_PER_SEC           1000
`define SEC_PER_MIN          60
`define HYST_SCALE           1000
`define RATE_WINDOW_MIN      17'h00014

// Register byte offsets
`define CMP_CTRL_OFS         12'h000
`define CMP_SELECT_OFS       12'h004
`define CMP_THRESH_OFS       12'h008
`define CMP_HYST_OFS         12'h00c
`define CMP_WINDOW_OFS       12'h010
`define CMP_DELAY_OFS        12'h014
`define CMP_STATUS_OFS       12'h018
`define CMP_SIGNAL_OFS       12'h01c
`define TMR_STATE_OFS        12'h020
`define TMR_DELAY_BASE       12'h100
`define TMR_TYPE_BASE        12'h180
`define TMR_REGION_MASK      12'hf80

// Control field positions
`define CTRL_ENABLE_BIT      0
`define CTRL_ABS_BIT         1
`define CTRL_DELTA_BIT       2
`define CTRL_UNDER_BIT       3
`define CTRL_UNIT_LSB        4

// Reset values
`define CMP_CTRL_RST         6'h00
`define CMP_SELECT_RST       16'h0000
`define CMP_THRESH_RST       18'h003e8
`define CMP_HYST_RST         9'h01e
`define CMP_WINDOW_RST       17'h00014
`define CMP_DELAY_RST        32'h00000000
`define TMR_DELAY_RST        32'h00000000
`define TMR_TYPE_RST         2'h0

`endif

/* common/cmp_timer_pkg.sv */
package cmp_timer_pkg;

    typedef enum logic [1:0] {
        UNIT_MS  = 2'b00,
        UNIT_SEC = 2'b01,
        UNIT_MIN = 2'b10
    } timeUnit_e;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axiResp_e;

endpackage

/* core/delay_stage.sv */
`timescale 1ns/1ps
`include "cmp_timer_params.svh"

module delay_stage #(
    parameter int CNT_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             tick,
    input  wire logic             level,
    input  wire logic [CNT_W-1:0] assertDelay,
    input  wire logic [CNT_W-1:0] releaseDelay,
    output logic                  delayed
);

    if (CNT_W < 1) begin : gCheck
        $error("bad CNT_W");
    end

    logic [CNT_W-1:0] cntFf;
    logic [CNT_W-1:0] nxt_cnt;
    logic             outFf;
    logic             nxt_out;
    logic [CNT_W-1:0] curDelay;

    assign curDelay = level ? assertDelay : releaseDelay;
    assign delayed  = outFf;

    // First tick may land mid-period, so a delay of N ticks lasts N-1 to N periods
    always_comb begin
        nxt_cnt = cntFf;
        nxt_out = outFf;
        if (clear) begin
            nxt_cnt = '0;
            nxt_out = 1'b0;
        end else if (level == outFf) begin
            nxt_cnt = '0;
        end else if (curDelay == '0) begin
            nxt_out = level;
            nxt_cnt = '0;
        end else if (tick) begin
            if (cntFf == CNT_W'(curDelay - 1'b1)) begin
                nxt_out = level;
                nxt_cnt = '0;
            end else begin
                nxt_cnt = CNT_W'(cntFf + 1'b1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cntFf <= '0;
            outFf <= 1'b0;
        end else begin
            cntFf <= nxt_cnt;
            outFf <= nxt_out;
        end
    end

endmodule

/* core/threshold_comparator_timers.sv */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cmp_timer_params.svh"

module threshold_comparator_timers #(
    parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES_DEF,
    parameter int NUM_TIMERS     = 32
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic [11:0]           awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [11:0]           araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [7:0]                 nonInvertedInputSelect,
    output logic [7:0]                 invertedInputSelect,
    input  wire logic signed [31:0]    nonInvertedValue,
    input  wire logic signed [31:0]    invertedValue,
    input  wire logic [7:0]            nonInvertedType,
    input  wire logic [7:0]            invertedType,
    input  wire logic                  comparatorInhibit,
    output logic                       comparatorPickup,
    output logic                       comparatorOperate,
    input  wire logic [NUM_TIMERS-1:0] timerIn,
    output logic [NUM_TIMERS-1:0]      timerOut
);

    localparam int MS_W = $clog2(MS_TICK_CYCLES);

    if (MS_TICK_CYCLES < 2 || NUM_TIMERS < 1 || NUM_TIMERS > 32) begin : gCheck
        $error("bad parameters");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? val[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    function automatic logic pickTick(input logic [1:0] unitSel, input logic ms, input logic sec, input logic mn);
        case (unitSel)
            cmp_timer_pkg::UNIT_SEC: pickTick = sec;
            cmp_timer_pkg::UNIT_MIN: pickTick = mn;
            default:                 pickTick = ms;
        endcase
    endfunction

    // Time base
    logic [MS_W-1:0] msCntFf;
    logic [MS_W-1:0] nxt_msCnt;
    logic [9:0]      secCntFf;
    logic [9:0]      nxt_secCnt;
    logic [5:0]      minCntFf;
    logic [5:0]      nxt_minCnt;
    logic            msTick;
    logic            secTick;
    logic            minTick;

    assign msTick  = msCntFf == MS_W'(MS_TICK_CYCLES - 1);
    assign secTick = msTick && secCntFf == 10'(`MS_PER_SEC - 1);
    assign minTick = secTick && minCntFf == 6'(`SEC_PER_MIN - 1);

    always_comb begin
        nxt_msCnt  = msTick ? '0 : MS_W'(msCntFf + 1'b1);
        nxt_secCnt = secCntFf;
        nxt_minCnt = minCntFf;
        if (msTick) begin
            nxt_secCnt = secTick ? '0 : 10'(secCntFf + 1'b1);
        end
        if (secTick) begin
            nxt_minCnt = minTick ? '0 : 6'(minCntFf + 1'b1);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            msCntFf  <= '0;
            secCntFf <= '0;
            minCntFf <= '0;
        end else begin
            msCntFf  <= nxt_msCnt;
            secCntFf <= nxt_secCnt;
            minCntFf <= nxt_minCnt;
        end
    end

    // Register bus, write side
    logic        awHeldFf;
    logic        nxt_awHeld;
    logic [11:0] awAddrFf;
    logic [11:0] nxt_awAddr;
    logic        wHeldFf;
    logic        nxt_wHeld;
    logic [31:0] wDataFf;
    logic [31:0] nxt_wData;
    logic [3:0]  wStrbFf;
    logic [3:0]  nxt_wStrb;
    logic        bvalidFf;
    logic        nxt_bvalid;
    logic [1:0]  brespFf;
    logic [1:0]  nxt_bresp;
    logic        doWrite;
    logic        wrErr;

    assign awready = !awHeldFf && !bvalidFf;
    assign wready  = !wHeldFf && !bvalidFf;
    assign bvalid  = bvalidFf;
    assign bresp   = brespFf;
    assign doWrite = awHeldFf && wHeldFf && !bvalidFf;

    always_comb begin
        nxt_awHeld = awHeldFf;
        nxt_awAddr = awAddrFf;
        nxt_wHeld  = wHeldFf;
        nxt_wData  = wDataFf;
        nxt_wStrb  = wStrbFf;
        nxt_bvalid = bvalidFf;
        nxt_bresp  = brespFf;
        if (awvalid && awready) begin
            nxt_awHeld = 1'b1;
            nxt_awAddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_wHeld = 1'b1;
            nxt_wData = wdata;
            nxt_wStrb = wstrb;
        end
        if (doWrite) begin
            nxt_awHeld = 1'b0;
            nxt_wHeld  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = wrErr ? cmp_timer_pkg::RESP_SLVERR : cmp_timer_pkg::RESP_OKAY;
        end
        if (bvalidFf && bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            awHeldFf <= 1'b0;
            awAddrFf <= '0;
            wHeldFf  <= 1'b0;
            wDataFf  <= '0;
            wStrbFf  <= '0;
            bvalidFf <= 1'b0;
            brespFf  <= cmp_timer_pkg::RESP_OKAY;
        end else begin
            awHeldFf <= nxt_awHeld;
            awAddrFf <= nxt_awAddr;
            wHeldFf  <= nxt_wHeld;
            wDataFf  <= nxt_wData;
            wStrbFf  <= nxt_wStrb;
            bvalidFf <= nxt_bvalid;
            brespFf  <= nxt_bresp;
        end
    end

    // Settings
    logic [5:0]         ctrlFf;
    logic [5:0]         nxt_ctrl;
    logic [15:0]        selFf;
    logic [15:0]        nxt_sel;
    logic signed [17:0] thrFf;
    logic signed [17:0] nxt_thr;
    logic [8:0]         hystFf;
    logic [8:0]         nxt_hyst;
    logic [16:0]        winLenFf;
    logic [16:0]        nxt_winLen;
    logic [31:0]        cmpDelayFf;
    logic [31:0]        nxt_cmpDelay;
    logic [31:0]        tmrDelayFf [NUM_TIMERS];
    logic [31:0]        nxt_tmrDelay [NUM_TIMERS];
    logic [1:0]         tmrTypeFf [NUM_TIMERS];
    logic [1:0]         nxt_tmrType [NUM_TIMERS];
    logic [4:0]         wrIdx;

    assign wrIdx = awAddrFf[6:2];

    always_comb begin
        nxt_ctrl     = ctrlFf;
        nxt_sel      = selFf;
        nxt_thr      = thrFf;
        nxt_hyst     = hystFf;
        nxt_winLen   = winLenFf;
        nxt_cmpDelay = cmpDelayFf;
        nxt_tmrDelay = tmrDelayFf;
        nxt_tmrType  = tmrTypeFf;
        wrErr        = 1'b0;
        case (awAddrFf)
            `CMP_CTRL_OFS:   nxt_ctrl = 6'(merge({26'h0, ctrlFf}, wDataFf, wStrbFf));
            `CMP_SELECT_OFS: nxt_sel = 16'(merge({16'h0, selFf}, wDataFf, wStrbFf));
            `CMP_THRESH_OFS: nxt_thr = 18'(merge({14'h0, thrFf}, wDataFf, wStrbFf));
            `CMP_HYST_OFS:   nxt_hyst = 9'(merge({23'h0, hystFf}, wDataFf, wStrbFf));
            `CMP_WINDOW_OFS: nxt_winLen = 17'(merge({15'h0, winLenFf}, wDataFf, wStrbFf));
            `CMP_DELAY_OFS:  nxt_cmpDelay = merge(cmpDelayFf, wDataFf, wStrbFf);
            default: begin
                if ((awAddrFf & `TMR_REGION_MASK) == `TMR_DELAY_BASE && int'(wrIdx) < NUM_TIMERS
                        && awAddrFf[1:0] == 2'h0) begin
                    nxt_tmrDelay[wrIdx] = merge(tmrDelayFf[wrIdx], wDataFf, wStrbFf);
                end else if ((awAddrFf & `TMR_REGION_MASK) == `TMR_TYPE_BASE && int'(wrIdx) < NUM_TIMERS
                        && awAddrFf[1:0] == 2'h0) begin
                    nxt_tmrType[wrIdx] = 2'(merge({30'h0, tmrTypeFf[wrIdx]}, wDataFf, wStrbFf));
                end else begin
                    wrErr = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrlFf     <= `CMP_CTRL_RST;
            selFf      <= `CMP_SELECT_RST;
            thrFf      <= `CMP_THRESH_RST;
            hystFf     <= `CMP_HYST_RST;
            winLenFf   <= `CMP_WINDOW_RST;
            cmpDelayFf <= `CMP_DELAY_RST;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                tmrDelayFf[i] <= `TMR_DELAY_RST;
                tmrTypeFf[i]  <= `TMR_TYPE_RST;
            end
        end else if (doWrite) begin
            ctrlFf     <= nxt_ctrl;
            selFf      <= nxt_sel;
            thrFf      <= nxt_thr;
            hystFf     <= nxt_hyst;
            winLenFf   <= nxt_winLen;
            cmpDelayFf <= nxt_cmpDelay;
            tmrDelayFf <= nxt_tmrDelay;
            tmrTypeFf  <= nxt_tmrType;
        end
    end

    assign nonInvertedInputSelect = selFf[7:0];
    assign invertedInputSelect    = selFf[15:8];

    // Comparator
    logic               bothOff;
    logic               typeMismatch;
    logic               qualify;
    logic               deltaMode;
    logic signed [33:0] diffSig;
    logic signed [33:0] levelSig;
    logic signed [33:0] evalSig;
    logic signed [33:0] thrExt;
    logic signed [33:0] bandSig;
    logic [16:0]        thrMag;
    logic [25:0]        bandProd;
    logic [16:0]        winEff;
    logic               winEnd;
    logic               rawPkpFf;
    logic               nxt_rawPkp;
    logic signed [33:0] prevFf;
    logic signed [33:0] nxt_prev;
    logic signed [33:0] deltaFf;
    logic signed [33:0] nxt_delta;
    logic [16:0]        winCntFf;
    logic [16:0]        nxt_winCnt;

    assign bothOff      = selFf[7:0] == 8'h00 && selFf[15:8] == 8'h00;
    assign typeMismatch = selFf[7:0] != 8'h00 && selFf[15:8] != 8'h00 && nonInvertedType != invertedType;
    assign qualify      = ctrlFf[`CTRL_ENABLE_BIT] && !comparatorInhibit && !bothOff && !typeMismatch;
    assign deltaMode    = ctrlFf[`CTRL_DELTA_BIT];
    assign diffSig      = (selFf[7:0] != 8'h00 ? 34'(nonInvertedValue) : 34'sh0)
                        - (selFf[15:8] != 8'h00 ? 34'(invertedValue) : 34'sh0);
    assign levelSig     = (ctrlFf[`CTRL_ABS_BIT] && diffSig < 0) ? -diffSig : diffSig;
    assign evalSig      = deltaMode ? deltaFf : levelSig;
    assign thrExt       = 34'(thrFf);
    assign thrMag       = thrFf[17] ? 17'(-thrFf) : 17'(thrFf);
    assign bandProd     = 26'(thrMag) * 26'(hystFf);
    assign bandSig      = signed'(34'(bandProd / 26'(`HYST_SCALE)));
    // Short windows are held at the floor rather than refused
    assign winEff       = winLenFf < `RATE_WINDOW_MIN ? `RATE_WINDOW_MIN : winLenFf;
    assign winEnd       = pickTick(ctrlFf[`CTRL_UNIT_LSB +: 2], msTick, secTick, minTick)
                        && winCntFf == 17'(winEff - 1'b1);

    always_comb begin
        nxt_rawPkp = 1'b0;
        nxt_prev   = prevFf;
        nxt_delta  = deltaFf;
        nxt_winCnt = winCntFf;
        if (!qualify || !deltaMode) begin
            nxt_prev   = levelSig;
            nxt_delta  = 34'sh0;
            nxt_winCnt = '0;
        end else if (winEnd) begin
            nxt_delta  = levelSig - prevFf;
            nxt_prev   = levelSig;
            nxt_winCnt = '0;
        end else if (pickTick(ctrlFf[`CTRL_UNIT_LSB +: 2], msTick, secTick, minTick)) begin
            nxt_winCnt = 17'(winCntFf + 1'b1);
        end
        if (qualify) begin
            if (ctrlFf[`CTRL_UNDER_BIT]) begin
                nxt_rawPkp = rawPkpFf ? !(evalSig > thrExt + bandSig) : (evalSig < thrExt);
            end else begin
                nxt_rawPkp = rawPkpFf ? !(evalSig < thrExt - bandSig) : (evalSig > thrExt);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rawPkpFf <= 1'b0;
            prevFf   <= 34'sh0;
            deltaFf  <= 34'sh0;
            winCntFf <= '0;
        end else begin
            rawPkpFf <= nxt_rawPkp;
            prevFf   <= nxt_prev;
            deltaFf  <= nxt_delta;
            winCntFf <= nxt_winCnt;
        end
    end

    assign comparatorPickup = rawPkpFf;

    delay_stage #(
        .CNT_W (16)
    ) uCmpDelay (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .clear        (!qualify),
        .tick         (msTick),
        .level        (rawPkpFf),
        .assertDelay  (cmpDelayFf[15:0]),
        .releaseDelay (cmpDelayFf[31:16]),
        .delayed      (comparatorOperate)
    );

    for (genvar g = 0; g < NUM_TIMERS; g++) begin : gTimer
        delay_stage #(
            .CNT_W (16)
        ) uStage (
            .sys_clk      (sys_clk),
            .reset        (reset),
            .clear        (1'b0),
            .tick         (pickTick(tmrTypeFf[g], msTick, secTick, minTick)),
            .level        (timerIn[g]),
            .assertDelay  (tmrDelayFf[g][15:0]),
            .releaseDelay (tmrDelayFf[g][31:16]),
            .delayed      (timerOut[g])
        );
    end

    // Register bus, read side
    logic        rvalidFf;
    logic        nxt_rvalid;
    logic [31:0] rdataFf;
    logic [31:0] nxt_rdata;
    logic [1:0]  rrespFf;
    logic [1:0]  nxt_rresp;
    logic [31:0] rdWord;
    logic        rdErr;
    logic [4:0]  rdIdx;

    assign arready = !rvalidFf;
    assign rvalid  = rvalidFf;
    assign rdata   = rdataFf;
    assign rresp   = rrespFf;
    assign rdIdx   = araddr[6:2];

    always_comb begin
        rdWord = 32'h00000000;
        rdErr  = 1'b0;
        case (araddr)
            `CMP_CTRL_OFS:   rdWord = {26'h0, ctrlFf};
            `CMP_SELECT_OFS: rdWord = {16'h0, selFf};
            `CMP_THRESH_OFS: rdWord = {14'h0, thrFf};
            `CMP_HYST_OFS:   rdWord = {23'h0, hystFf};
            `CMP_WINDOW_OFS: rdWord = {15'h0, winLenFf};
            `CMP_DELAY_OFS:  rdWord = cmpDelayFf;
            `CMP_STATUS_OFS: rdWord = {28'h0, qualify, typeMismatch, comparatorOperate, rawPkpFf};
            `CMP_SIGNAL_OFS: rdWord = 32'(evalSig);
            `TMR_STATE_OFS:  rdWord = 32'(timerOut);
            default: begin
                if ((araddr & `TMR_REGION_MASK) == `TMR_DELAY_BASE && int'(rdIdx) < NUM_TIMERS
                        && araddr[1:0] == 2'h0) begin
                    rdWord = tmrDelayFf[rdIdx];
                end else if ((araddr & `TMR_REGION_MASK) == `TMR_TYPE_BASE && int'(rdIdx) < NUM_TIMERS
                        && araddr[1:0] == 2'h0) begin
                    rdWord = {30'h0, tmrTypeFf[rdIdx]};
                end else begin
                    rdErr = 1'b1;
                end
            end
        endcase
    end

    always_comb begin
        nxt_rvalid = rvalidFf;
        nxt_rdata  = rdataFf;
        nxt_rresp  = rrespFf;
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = rdWord;
            nxt_rresp  = rdErr ? cmp_timer_pkg::RESP_SLVERR : cmp_timer_pkg::RESP_OKAY;
        end else if (rvalidFf && rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rvalidFf <= 1'b0;
            rdataFf  <= '0;
            rrespFf  <= cmp_timer_pkg::RESP_OKAY;
        end else begin
            rvalidFf <= nxt_rvalid;
            rdataFf  <= nxt_rdata;
            rrespFf  <= nxt_rresp;
        end
    end

endmodule

/* bench/cmp_timer_asserts.sv */
`timescale 1ns/1ps
module cmp_timer_asserts #(
    parameter int NUM_TIMERS = 32
) (
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire logic                  awvalid,
    input wire logic                  awready,
    input wire logic                  wvalid,
    input wire logic                  wready,
    input wire logic                  bvalid,
    input wire logic                  arvalid,
    input wire logic                  arready,
    input wire logic                  rvalid,
    input wire logic [7:0]            nonInvertedInputSelect,
    input wire logic [7:0]            invertedInputSelect,
    input wire logic                  comparatorInhibit,
    input wire logic                  comparatorPickup,
    input wire logic                  comparatorOperate,
    input wire logic [NUM_TIMERS-1:0] timerIn,
    input wire logic [NUM_TIMERS-1:0] timerOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    inhibit_clears_a: assert property (comparatorInhibit |=> !comparatorPickup && !comparatorOperate)
        else $error("inhibit left an output set");
    both_off_a: assert property (nonInvertedInputSelect == 8'h00 && invertedInputSelect == 8'h00 |=> !comparatorPickup)
        else $error("pickup with both inputs off");
    timer_rise_a: assert property ((timerOut & ~$past(timerOut) & ~$past(timerIn)) == '0)
        else $error("timer output rose without input");
    timer_fall_a: assert property ((~timerOut & $past(timerOut) & $past(timerIn)) == '0)
        else $error("timer output fell with input high");
    operate_cause_a: assert property ($rose(comparatorOperate) |-> $past(comparatorPickup))
        else $error("operate rose without pickup");
    write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
        else $error("write response late");
    write_refuse_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    read_latency_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data not one cycle after address");
    cover property ($rose(comparatorPickup));
    cover property ($rose(comparatorOperate));
    cover property ($rose(timerOut[NUM_TIMERS-1]));
endmodule

bind threshold_comparator_timers cmp_timer_asserts #(.NUM_TIMERS(NUM_TIMERS)) checker_i (.*);

/* bench/measure_source_model.sv */
`timescale 1ns/1ps
module measure_source_model (
    input  wire logic               sys_clk,
    input  wire logic [7:0]         nonInvertedInputSelect,
    input  wire logic [7:0]         invertedInputSelect,
    input  wire logic signed [31:0] posLevel,
    input  wire logic signed [31:0] negLevel,
    input  wire logic               typeSkew,
    output logic signed [31:0]      nonInvertedValue,
    output logic signed [31:0]      invertedValue,
    output logic [7:0]              nonInvertedType,
    output logic [7:0]              invertedType
);
    logic [31:0] noise_ff = 32'h5a5a0f0f;
    // Unselected inputs carry junk so a missing zero shows up
    always_ff @(posedge sys_clk) begin
        noise_ff <= {noise_ff[30:0], ~noise_ff[31]};
    end
    assign nonInvertedValue = (nonInvertedInputSelect != 8'h00) ? posLevel : noise_ff;
    assign invertedValue    = (invertedInputSelect != 8'h00) ? negLevel : ~noise_ff;
    assign nonInvertedType  = (nonInvertedInputSelect != 8'h00) ? 8'h01 : noise_ff[7:0];
    assign invertedType     = (invertedInputSelect != 8'h00) ? {6'h00, typeSkew, ~typeSkew} : noise_ff[15:8];
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "cmp_timer_params.svh"
module testbench;
    localparam int TK = 4;
    localparam logic [1:0] OK = cmp_timer_pkg::RESP_OKAY;
    localparam logic [1:0] ER = cmp_timer_pkg::RESP_SLVERR;
    logic               sys_clk, reset, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic               arready, rvalid, comparatorInhibit, comparatorPickup, comparatorOperate, typeSkew;
    logic [11:0]        awaddr, araddr;
    logic [31:0]        wdata, rdata, timerIn, timerOut;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic [7:0]         nonInvertedInputSelect, invertedInputSelect, nonInvertedType, invertedType;
    logic signed [31:0] nonInvertedValue, invertedValue, posLevel, negLevel;
    int                 miscompares, checks;

    threshold_comparator_timers #(.MS_TICK_CYCLES(TK)) dut (.*);
    measure_source_model model (.*);

    always #2.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        {araddr, arvalid} <= {a, 1'b1};
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // Bits of ctrl: enable, absolute, delta, under
    task automatic cmpCase(input logic [31:0] ctrl, sel, thr, input logic signed [31:0] p, n, input logic sk, ih, ex);
        posLevel <= p;
        negLevel <= n;
        typeSkew <= sk;
        comparatorInhibit <= ih;
        wr(`CMP_CTRL_OFS, ctrl, OK);
        wr(`CMP_SELECT_OFS, sel, OK);
        wr(`CMP_THRESH_OFS, thr, OK);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, comparatorPickup}, {31'h0, ex});
        @(posedge sys_clk);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        stop_test;
    end

    initial begin
        {sys_clk, awvalid, wvalid, arvalid, comparatorInhibit, typeSkew} = '0;
        {awaddr, araddr, wdata, timerIn, posLevel, negLevel} = '0;
        {bready, rready, reset, wstrb} = 7'h7f;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(`CMP_CTRL_OFS, 32'h0, OK);
        rd(`CMP_THRESH_OFS, 32'h3e8, OK);
        rd(`CMP_HYST_OFS, 32'h1e, OK);
        rd(`CMP_WINDOW_OFS, 32'h14, OK);
        wr(`CMP_WINDOW_OFS, 32'h15180, OK);
        rd(`CMP_WINDOW_OFS, 32'h15180, OK);
        rd(12'h040, 32'h0, ER);
        wr(`CMP_STATUS_OFS, 32'h1, ER);
        $display("test registers done");
        wr(`TMR_DELAY_BASE + 12'h004, 32'h00020003, OK);
        wr(`TMR_TYPE_BASE + 12'h07c, 32'h1, OK);
        wr(`TMR_DELAY_BASE + 12'h07c, 32'h1, OK);
        rd(`TMR_TYPE_BASE + 12'h07c, 32'h1, OK);
        timerIn <= 32'h80000003;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(timerOut & 32'h3, 32'h1);
        repeat (2 * TK - 2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(timerOut & 32'h3, 32'h1);
        repeat (2 * TK - 1) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(timerOut & 32'h3, 32'h3);
        @(posedge sys_clk);
        timerIn <= 32'h80000000;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(timerOut & 32'h3, 32'h2);
        repeat (2 * TK + 2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(timerOut, 32'h0);
        repeat (975 * TK) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(timerOut, 32'h0);
        repeat (20 * TK) @(posedge sys_clk);
        rd(`TMR_STATE_OFS, 32'h80000000, OK);
        timerIn <= 32'h0;
        $display("test timers done");
        cmpCase(32'h1, 32'h1, 32'h3e8, 1500, 0, 0, 0, 1);
        cmpCase(32'h1, 32'h1, 32'h3e8, 980, 0, 0, 0, 1);
        cmpCase(32'h1, 32'h1, 32'h3e8, 960, 0, 0, 0, 0);
        cmpCase(32'h9, 32'h1, 32'h3fe0c, -600, 0, 0, 0, 1);
        cmpCase(32'h9, 32'h1, 32'h3fe0c, -400, 0, 0, 0, 0);
        cmpCase(32'h3, 32'h201, 32'h3e8, 100, 2000, 0, 0, 1);
        cmpCase(32'h1, 32'h201, 32'h3e8, 100, 2000, 0, 0, 0);
        cmpCase(32'h1, 32'h0, 32'h3fe0c, 0, 0, 0, 0, 0);
        cmpCase(32'h1, 32'h201, 32'h3fe0c, 0, 0, 0, 0, 1);
        cmpCase(32'h1, 32'h201, 32'h3fe0c, 0, 0, 1, 0, 0);
        cmpCase(32'h1, 32'h201, 32'h3fe0c, 0, 0, 0, 1, 0);
        cmpCase(32'h5, 32'h1, 32'h3e8, 5000, 0, 0, 0, 0);
        wr(`CMP_DELAY_OFS, 32'h2, OK);
        cmpCase(32'h1, 32'h1, 32'h3e8, 0, 0, 0, 0, 0);
        posLevel <= 1500;
        do @(negedge sys_clk); while (comparatorPickup !== 1'b1);
        chk({31'h0, comparatorOperate}, 32'h0);
        repeat (2 * TK + 2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, comparatorOperate}, 32'h1);
        $display("test comparator done");
        stop_test;
    end
endmodule
